// *** pkg/cffc_pkg.sv ***
// Shared constants for the column flat-field corrector.
// Assumes 32-bit classic Wishbone registers and 12-bit pixels.
`default_nettype none
package cffc_pkg;
	// Pixel, column and coefficient widths
	localparam int PIX_W     = 12;
	localparam int COL_W     = 10;
	localparam int COLS      = 1024;
	localparam int COEF_W    = 16;
	localparam int GL_W      = 2;
	localparam int FACT_AW   = GL_W + COL_W;
	localparam int WORD_W    = 2 * COEF_W;
	localparam int GAIN_FRAC = 12;
	localparam int SUM_W     = COEF_W + 2;
	localparam int PROD_W    = SUM_W - 1 + COEF_W;

	// Coefficient identity: unity gain, zero offset
	localparam logic [COEF_W-1:0] GAIN_UNITY  = 16'h1000;
	localparam logic [COEF_W-1:0] OFFSET_ZERO = 16'h0000;
	localparam logic [WORD_W-1:0] IDENTITY_WORD = {GAIN_UNITY, OFFSET_ZERO};

	// Offset step: offsets must be multiples of two to this power
	localparam int OFF_STEP_LOG2 = 5;
	localparam logic [31:0] OFF_STEP = 32'h0000_0020;

	// Column helpers
	localparam logic [COL_W-1:0] COL_ONE  = 10'h001;
	localparam logic [COL_W-1:0] COL_LAST = 10'h3FF;

	// Register byte offsets
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_COLIDX = 8'h04;
	localparam logic [7:0] REG_GAIN   = 8'h08;
	localparam logic [7:0] REG_OFFSET = 8'h0C;
	localparam logic [7:0] REG_STEP   = 8'h10;
	localparam logic [7:0] REG_CMD    = 8'h14;
	localparam logic [7:0] REG_STATUS = 8'h18;

	// Field positions
	localparam int CTRL_EN      = 0;
	localparam int CTRL_MODE    = 1;
	localparam int CMD_RELOAD   = 0;
	localparam int CMD_SAVE     = 1;
	localparam int STAT_BUSY    = 0;
	localparam int STAT_OFFERR  = 1;
	localparam int STAT_SAVED   = 2;
	localparam int STAT_DENIED  = 3;

	// Correction mode codes
	localparam logic [1:0] MODE_FACTORY = 2'h0;
	localparam logic [1:0] MODE_USER    = 2'h1;
	localparam logic [1:0] MODE_CALIB   = 2'h2;
	localparam logic [1:0] MODE_RSVD    = 2'h3;

	// Values after reset
	localparam logic       EN_RST   = 1'b1;
	localparam logic [1:0] MODE_RST = MODE_FACTORY;

	// Table walker states
	typedef enum logic [1:0] {WALK_IDLE, WALK_LOAD, WALK_SAVE} cffc_walk_e;
endpackage
`default_nettype wire

// *** core/cffc_coef_mem.sv ***
// Coefficient table: one write port, one registered read port.
// Assumes a single clock; read data lags the address by one cycle.
`default_nettype none
module cffc_coef_mem
	import cffc_pkg::*;
#(
	parameter int W  = WORD_W,
	parameter int AW = COL_W
)
(
	input  wire logic          mclk,
	input  wire logic          we,
	input  wire logic [AW-1:0] waddr,
	input  wire logic [W-1:0]  wdata,
	input  wire logic [AW-1:0] raddr,
	output logic      [W-1:0]  rdata
);
	logic [W-1:0] mem [0:(1<<AW)-1];

	// Write, then registered read
	always_ff @(posedge mclk)
	begin
		if (we)
			mem[waddr] <= wdata;
		rdata <= mem[raddr];
	end
endmodule // cffc_coef_mem
`default_nettype wire

// *** core/cffc_scale.sv ***
// Offset-then-gain arithmetic with saturation, purely combinational.
// Assumes unsigned pixels, signed offsets and unsigned fixed-point gain.
`default_nettype none
module cffc_scale
	import cffc_pkg::*;
(
	input  wire logic [PIX_W-1:0]  pix,
	input  wire logic [COEF_W-1:0] gain,
	input  wire logic [COEF_W-1:0] offset,
	output logic      [PIX_W-1:0]  result
);
	logic signed [SUM_W-1:0] sum;
	logic        [PROD_W-1:0] prod;

	// Add offset first, scale second, clamp both ends
	always_comb
	begin
		sum = $signed({{(SUM_W-PIX_W){1'b0}}, pix})
			+ $signed({{(SUM_W-COEF_W){offset[COEF_W-1]}}, offset});
		prod = sum[SUM_W-2:0] * gain;
		if (sum[SUM_W-1])
			result = '0;
		else if (|prod[PROD_W-1:GAIN_FRAC+PIX_W])
			result = '1;
		else
			result = prod[GAIN_FRAC+PIX_W-1:GAIN_FRAC];
	end
endmodule // cffc_scale
`default_nettype wire

// *** core/cffc_column_corrector.sv ***
// Column flat-field corrector: per-column offset and gain on a pixel stream.
// Assumes a classic Wishbone master, pixels synchronous to mclk, and a
// factory coefficient store that answers factAddr in the same cycle.
//
// Behaviour
// - Each pixel gets its column offset added first and the sum is then scaled by the gain.
// - Coefficients are looked up by column and never by row, so all rows share them.
// - A correction enable exists and is on after reset.
// - There are three modes, factory, user and calibration, with factory after reset.
// - Factory mode uses factory coefficients chosen by the camera gain level.
// - User mode uses the user table whatever the camera gain level is.
// - The user table starts as zero offset and unity gain.
// - User table writes are accepted only in calibration mode.
// - Calibration opens the table, forces correction off and locks the enable.
// - Table edits act on pixels only after returning to user mode and re-enabling.
// - A column index picks the table entry that gain and offset accesses reach.
// - Offsets are 16 bits, must be multiples of a readable step, else an error is flagged.
// - A reload command restores the saved table, or identity if nothing was saved.
// - A save command copies the whole user table over the saved copy.
`default_nettype none
module cffc_column_corrector
	import cffc_pkg::*;
(
	input  wire logic                mclk,
	input  wire logic                reset,
	input  wire logic                wb_cyc_i,
	input  wire logic                wb_stb_i,
	input  wire logic                wb_we_i,
	input  wire logic [7:0]          wb_adr_i,
	input  wire logic [3:0]          wb_sel_i,
	input  wire logic [31:0]         wb_dat_i,
	output logic      [31:0]         wb_dat_o,
	output logic                     wb_ack_o,
	input  wire logic [PIX_W-1:0]    pixIn,
	input  wire logic                pixValid,
	input  wire logic                lineStart,
	input  wire logic [GL_W-1:0]     cameraGainLevel,
	input  wire logic [COEF_W-1:0]   factGain,
	input  wire logic [COEF_W-1:0]   factOffset,
	output logic      [FACT_AW-1:0]  factAddr,
	output logic      [PIX_W-1:0]    pixOut,
	output logic                     pixOutValid,
	output logic                     pixOutLineStart
);
	// Control state
	logic             enableQ, enableD;
	logic [1:0]       modeQ, modeD;
	logic [COL_W-1:0] colIdxQ, colIdxD;
	logic             offErrQ, offErrD;
	logic             deniedQ, deniedD;
	logic             savedQ, savedD;
	// Bus state
	logic             ackQ, ackD;
	logic [31:0]      datQ, datD;
	logic [31:0]      rdWord;
	// Walker state
	cffc_walk_e       walkQ, walkD;
	logic [COL_W-1:0] idxQ, idxD;
	logic             wrPendQ, wrPendD;
	logic [COL_W-1:0] wrAddrQ, wrAddrD;
	logic             toSavedQ, toSavedD;
	logic             useSavedQ, useSavedD;
	// Pixel pipeline state
	logic [COL_W-1:0] colQ, colD;
	logic [PIX_W-1:0] p1PixQ, p1PixD;
	logic             p1ValidQ, p1ValidD;
	logic             p1LineQ, p1LineD;
	logic [FACT_AW-1:0] factAddrD;
	logic [PIX_W-1:0] outPixD;
	logic             outValidD, outLineD;
	// Wires
	logic             busReq, busWr, calib, busy, corrOn;
	logic             cmdReload, cmdSave, userBusWe, saveDone;
	logic [1:0]       newMode;
	logic [WORD_W-1:0] userBusData, userRd, savedRd, userWdata;
	logic [COL_W-1:0] pixCol, userRaddr, userWaddr;
	logic             userWe, savedWe;
	logic [COEF_W-1:0] selGain, selOff;
	logic [PIX_W-1:0] scaled;

	assign busReq = wb_cyc_i & wb_stb_i & ~ackQ;
	assign busWr  = busReq & wb_we_i;
	assign calib  = (modeQ == MODE_CALIB);
	assign busy   = (walkQ != WALK_IDLE) | wrPendQ;
	assign corrOn = enableQ & ~calib;
	assign newMode = wb_dat_i[CTRL_MODE +: 2];

	// Control registers, table access gating and sticky flags
	always_comb
	begin
		enableD = enableQ;
		modeD = modeQ;
		colIdxD = colIdxQ;
		offErrD = offErrQ;
		deniedD = deniedQ;
		savedD = savedQ;
		cmdReload = 1'b0;
		cmdSave = 1'b0;
		userBusWe = 1'b0;
		userBusData = userRd;
		// Write-one-to-clear first so a same-cycle event still sets
		if (busWr && wb_adr_i == REG_STATUS && wb_sel_i[0])
		begin
			offErrD = offErrQ & ~wb_dat_i[STAT_OFFERR];
			deniedD = deniedQ & ~wb_dat_i[STAT_DENIED];
		end
		if (busWr && wb_adr_i == REG_CTRL && wb_sel_i[0])
		begin
			if (!calib)
				enableD = wb_dat_i[CTRL_EN];
			if (busy || newMode == MODE_RSVD)
				deniedD = 1'b1;
			else
			begin
				modeD = newMode;
				if (newMode == MODE_CALIB)
					enableD = 1'b0;
			end
		end
		if (busWr && wb_adr_i == REG_COLIDX && (&wb_sel_i[1:0]))
			colIdxD = wb_dat_i[COL_W-1:0];
		if (busWr && wb_adr_i == REG_GAIN && (&wb_sel_i[1:0]))
		begin
			if (!calib || busy)
				deniedD = 1'b1;
			else
			begin
				userBusWe = 1'b1;
				userBusData = {wb_dat_i[COEF_W-1:0], userRd[COEF_W-1:0]};
			end
		end
		if (busWr && wb_adr_i == REG_OFFSET && (&wb_sel_i[1:0]))
		begin
			if (|wb_dat_i[OFF_STEP_LOG2-1:0])
				offErrD = 1'b1;
			else if (!calib || busy)
				deniedD = 1'b1;
			else
			begin
				userBusWe = 1'b1;
				userBusData = {userRd[WORD_W-1:COEF_W], wb_dat_i[COEF_W-1:0]};
			end
		end
		if (busWr && wb_adr_i == REG_CMD && wb_sel_i[0])
		begin
			if ((wb_dat_i[CMD_RELOAD] | wb_dat_i[CMD_SAVE]) && (!calib || busy))
				deniedD = 1'b1;
			else
			begin
				cmdReload = wb_dat_i[CMD_RELOAD];
				cmdSave = wb_dat_i[CMD_SAVE] & ~wb_dat_i[CMD_RELOAD];
			end
		end
		if (saveDone)
			savedD = 1'b1;
	end

	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			enableQ <= EN_RST;
			modeQ <= MODE_RST;
			colIdxQ <= '0;
			offErrQ <= 1'b0;
			deniedQ <= 1'b0;
			savedQ <= 1'b0;
		end
		else
		begin
			enableQ <= enableD;
			modeQ <= modeD;
			colIdxQ <= colIdxD;
			offErrQ <= offErrD;
			deniedQ <= deniedD;
			savedQ <= savedD;
		end
	end

	// Read mux and one-cycle acknowledge
	always_comb
	begin
		rdWord = '0;
		case (wb_adr_i)
			REG_CTRL:
			begin
				rdWord[CTRL_EN] = enableQ;
				rdWord[CTRL_MODE +: 2] = modeQ;
			end
			REG_COLIDX: rdWord[COL_W-1:0] = colIdxQ;
			REG_GAIN:
				if (calib)
					rdWord[COEF_W-1:0] = userRd[WORD_W-1:COEF_W];
			REG_OFFSET:
				if (calib)
					rdWord[COEF_W-1:0] = userRd[COEF_W-1:0];
			REG_STEP: rdWord = OFF_STEP;
			REG_STATUS:
			begin
				rdWord[STAT_BUSY] = busy;
				rdWord[STAT_OFFERR] = offErrQ;
				rdWord[STAT_SAVED] = savedQ;
				rdWord[STAT_DENIED] = deniedQ;
			end
			default: rdWord = '0;
		endcase
		ackD = busReq;
		datD = (busReq && !wb_we_i) ? rdWord : '0;
	end

	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			ackQ <= 1'b0;
			datQ <= '0;
		end
		else
		begin
			ackQ <= ackD;
			datQ <= datD;
		end
	end

	assign wb_ack_o = ackQ;
	assign wb_dat_o = datQ;

	// Table walker for reload and save; reset starts an identity load
	always_comb
	begin
		walkD = walkQ;
		idxD = idxQ;
		wrPendD = 1'b0;
		wrAddrD = idxQ;
		toSavedD = (walkQ == WALK_SAVE);
		useSavedD = useSavedQ;
		case (walkQ)
			WALK_IDLE:
				if (cmdReload)
				begin
					walkD = WALK_LOAD;
					idxD = '0;
					useSavedD = savedQ;
				end
				else if (cmdSave)
				begin
					walkD = WALK_SAVE;
					idxD = '0;
				end
			WALK_LOAD, WALK_SAVE:
			begin
				wrPendD = 1'b1;
				idxD = idxQ + COL_ONE;
				if (idxQ == COL_LAST)
					walkD = WALK_IDLE;
			end
			default: walkD = WALK_IDLE;
		endcase
	end

	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			walkQ <= WALK_LOAD;
			idxQ <= '0;
			wrPendQ <= 1'b0;
			wrAddrQ <= '0;
			toSavedQ <= 1'b0;
			useSavedQ <= 1'b0;
		end
		else
		begin
			walkQ <= walkD;
			idxQ <= idxD;
			wrPendQ <= wrPendD;
			wrAddrQ <= wrAddrD;
			toSavedQ <= toSavedD;
			useSavedQ <= useSavedD;
		end
	end

	// Table port steering: walker, then bus in calibration, else pixels
	assign saveDone  = wrPendQ & toSavedQ & (wrAddrQ == COL_LAST);
	assign userRaddr = (walkQ != WALK_IDLE) ? idxQ : (calib ? colIdxQ : pixCol);
	assign userWe    = (wrPendQ & ~toSavedQ) | userBusWe;
	assign userWaddr = wrPendQ ? wrAddrQ : colIdxQ;
	assign userWdata = wrPendQ ? (useSavedQ ? savedRd : IDENTITY_WORD) : userBusData;
	assign savedWe   = wrPendQ & toSavedQ;

	cffc_coef_mem userTable (
		.mclk  (mclk),
		.we    (userWe),
		.waddr (userWaddr),
		.wdata (userWdata),
		.raddr (userRaddr),
		.rdata (userRd)
	);

	cffc_coef_mem savedTable (
		.mclk  (mclk),
		.we    (savedWe),
		.waddr (wrAddrQ),
		.wdata (userRd),
		.raddr (idxQ),
		.rdata (savedRd)
	);

	// Column counter and first pixel stage, coefficient fetch issued here
	always_comb
	begin
		pixCol = lineStart ? '0 : colQ;
		colD = colQ;
		if (pixValid)
			colD = pixCol + COL_ONE;
		p1PixD = pixIn;
		p1ValidD = pixValid;
		p1LineD = pixValid & lineStart;
		factAddrD = {cameraGainLevel, pixCol};
	end

	// Second stage: pick coefficient set, correct or bypass
	always_comb
	begin
		selGain = userRd[WORD_W-1:COEF_W];
		selOff = userRd[COEF_W-1:0];
		if (modeQ == MODE_FACTORY)
		begin
			selGain = factGain;
			selOff = factOffset;
		end
		outPixD = corrOn ? scaled : p1PixQ;
		outValidD = p1ValidQ;
		outLineD = p1LineQ;
	end

	cffc_scale scaler (
		.pix    (p1PixQ),
		.gain   (selGain),
		.offset (selOff),
		.result (scaled)
	);

	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			colQ <= '0;
			p1PixQ <= '0;
			p1ValidQ <= 1'b0;
			p1LineQ <= 1'b0;
			factAddr <= '0;
			pixOut <= '0;
			pixOutValid <= 1'b0;
			pixOutLineStart <= 1'b0;
		end
		else
		begin
			colQ <= colD;
			p1PixQ <= p1PixD;
			p1ValidQ <= p1ValidD;
			p1LineQ <= p1LineD;
			factAddr <= factAddrD;
			pixOut <= outPixD;
			pixOutValid <= outValidD;
			pixOutLineStart <= outLineD;
		end
	end
endmodule // cffc_column_corrector
`default_nettype wire

// *** sim/cffc_column_corrector_properties.sv ***
// Port checker for the column corrector, bound into every instance.
// Assumes one clock domain and a synchronous active-high reset.
`default_nettype none
module cffc_column_corrector_checker
	import cffc_pkg::*;
(
	input wire logic               mclk,
	input wire logic               reset,
	input wire logic               wb_cyc_i,
	input wire logic               wb_stb_i,
	input wire logic [31:0]        wb_dat_o,
	input wire logic               wb_ack_o,
	input wire logic               pixValid,
	input wire logic               lineStart,
	input wire logic [GL_W-1:0]    cameraGainLevel,
	input wire logic [FACT_AW-1:0] factAddr,
	input wire logic               pixOutValid,
	input wire logic               pixOutLineStart
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);

	// Bus answer timing
	ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held too long");
	ack_next_cycle_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack late");
	ack_needs_req_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack without request");
	dat_idle_zero_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
		else $error("read data outside ack");

	// Pixel stream timing and column tracking
	pix_two_cycles_a: assert property (pixValid |=> ##1 pixOutValid)
		else $error("pixel output late");
	pix_no_extra_a: assert property (pixOutValid |-> $past(pixValid, 2))
		else $error("pixel output without input");
	line_start_delay_a: assert property (pixOutValid |-> pixOutLineStart == $past(lineStart, 2))
		else $error("line start misplaced");
	first_column_a: assert property (pixValid && lineStart |=>
		factAddr == {$past(cameraGainLevel), 10'h000})
		else $error("line start column not zero");
	column_step_a: assert property (pixValid && !lineStart && $past(pixValid) |=>
		factAddr[9:0] == $past(factAddr[9:0]) + 10'h001)
		else $error("column did not advance");

	// Main scenarios seen
	cover property (wb_ack_o);
	cover property (pixOutLineStart);
	cover property (pixValid && factAddr[9:0] == COL_LAST);
endmodule // cffc_column_corrector_checker

bind cffc_column_corrector cffc_column_corrector_checker u_chk (.mclk, .reset, .wb_cyc_i,
	.wb_stb_i, .wb_dat_o, .wb_ack_o, .pixValid, .lineStart, .cameraGainLevel, .factAddr,
	.pixOutValid, .pixOutLineStart);
`default_nettype wire

// *** sim/cffc_fact_model.sv ***
// Factory coefficient store model, one set per camera gain level.
// Assumes the corrector registers the address and scales in the next cycle.
`default_nettype none
module cffc_fact_model
	import cffc_pkg::*;
(
	input  wire logic [FACT_AW-1:0] factAddr,
	output logic      [COEF_W-1:0]  factGain,
	output logic      [COEF_W-1:0]  factOffset
);
	timeunit 1ns;
	timeprecision 1ns;

	// Gain grows with gain level, offset varies by column
	function automatic logic [31:0] coef(logic [11:0] a);
		return {16'h0E00 + {5'h00, a[11:10], 9'h000}, (16'h0020 * a[3:0]) - 16'h0100};
	endfunction

	// Lookup answers in the same cycle as the registered address
	always_comb
		{factGain, factOffset} = coef(factAddr);
endmodule // cffc_fact_model
`default_nettype wire

// *** sim/cffc_column_corrector_bench.sv ***
// Self-checking bench for the column corrector.
// Assumes the factory store model and the bound port checker.
`default_nettype none
module cffc_column_corrector_bench;
	timeunit 1ns;
	timeprecision 1ns;
	import cffc_pkg::*;
	logic                mclk = 1'b0;
	logic                reset = 1'b1;
	logic                wb_cyc_i = 1'b0;
	logic                wb_stb_i = 1'b0;
	logic                wb_we_i = 1'b0;
	logic [7:0]          wb_adr_i = 8'h00;
	logic [3:0]          wb_sel_i = 4'hF;
	logic [31:0]         wb_dat_i = 32'h0;
	logic [31:0]         wb_dat_o;
	logic                wb_ack_o;
	logic [PIX_W-1:0]    pixIn = 12'h000;
	logic                pixValid = 1'b0;
	logic                lineStart = 1'b0;
	logic [GL_W-1:0]     cameraGainLevel = 2'h0;
	logic [COEF_W-1:0]   factGain;
	logic [COEF_W-1:0]   factOffset;
	logic [FACT_AW-1:0]  factAddr;
	logic [PIX_W-1:0]    pixOut;
	logic                pixOutValid;
	logic                pixOutLineStart;
	int                  fails = 0;
	int                  comparisons = 0;
	int                  seed = 62;
	logic                en = 1'b1;
	logic [1:0]          md = MODE_FACTORY;
	logic [31:0]         tab [int];
	logic [31:0]         q [$];
	logic [31:0]         r;

	cffc_column_corrector u_dut (.mclk, .reset, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
		.wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .pixIn, .pixValid, .lineStart,
		.cameraGainLevel, .factGain, .factOffset, .factAddr, .pixOut, .pixOutValid,
		.pixOutLineStart);
	cffc_fact_model u_fm (.factAddr, .factGain, .factOffset);

	always #10 mclk = ~mclk;

	// Offset first, then gain, clamped
	function automatic logic [31:0] corr(logic [11:0] p, logic [15:0] g, logic [15:0] o);
		longint s;
		s = ((longint'(p) + longint'($signed(o))) * longint'(g)) >>> 12;
		return (s < 0) ? 32'h0 : (s > 4095) ? 32'hFFF : 32'(s);
	endfunction

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e)
		begin
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
			fails++;
		end
	endtask

	// Classic single bus cycle
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_sel_i <= 4'hF;
		wb_dat_i <= d;
		// Wait for the acknowledge; only the watchdog ends a missing one
		do
		begin
			@(posedge mclk);
		end
		while (wb_ack_o !== 1'b1);
		r = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask

	task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string nm);
		wb(1'b0, a, 32'h0);
		chk(nm, e, r);
	endtask

	// Poll until the table walker is idle
	task automatic idle;
		for (int k = 0; k < 40; k++)
		begin
			wb(1'b0, REG_STATUS, 32'h0);
			if (r[STAT_BUSY] === 1'b0)
				break;
			repeat (50) @(posedge mclk);
		end
		chk("walker idle", 32'h0, {31'h0, r[STAT_BUSY]});
	endtask

	// One line of pixels, expectation queued per pixel
	task automatic send(input int n, input logic [1:0] gl);
		logic [11:0] p;
		logic [31:0] c;
		for (int i = 0; i < n; i++)
		begin
			p = (i == 1) ? 12'hFFF : (i == 2) ? 12'h000 : 12'($random(seed));
			c = u_fm.coef({gl, 10'(i)});
			if (md == MODE_USER)
				c = tab.exists(i % COLS) ? tab[i % COLS] : IDENTITY_WORD;
			q.push_back((en && md != MODE_CALIB) ? corr(p, c[31:16], c[15:0]) : 32'(p));
			@(posedge mclk);
			pixValid <= 1'b1;
			lineStart <= (i == 0);
			cameraGainLevel <= gl;
			pixIn <= p;
		end
		@(posedge mclk);
		pixValid <= 1'b0;
		lineStart <= 1'b0;
		repeat (4) @(posedge mclk);
	endtask

	// Output pixel monitor
	always @(posedge mclk)
		if (pixOutValid === 1'b1)
			chk("pixOut", q.pop_front(), 32'(pixOut));

	task automatic tally_and_finish;
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	initial
	begin
		repeat (10) @(posedge mclk);
		reset <= 1'b0;
		rchk(REG_CTRL, 32'h1, "ctrl reset");
		rchk(REG_STEP, OFF_STEP, "step");
		rchk(8'h40, 32'h0, "unmapped");
		idle();
		$display("reset test done");
		for (int gl = 0; gl < 4; gl++)
			send(1030, 2'(gl));
		$display("factory test done");
		md = MODE_USER;
		wb(1'b1, REG_CTRL, 32'h3);
		send(40, 2'h2);
		wb(1'b1, REG_GAIN, 32'h1800);
		rchk(REG_STATUS, 32'h8, "denied");
		wb(1'b1, REG_STATUS, 32'h8);
		wb(1'b1, REG_CTRL, 32'h7);
		rchk(REG_STATUS, 32'h8, "reserved mode");
		rchk(REG_CTRL, 32'h3, "mode kept");
		wb(1'b1, REG_STATUS, 32'h8);
		md = MODE_CALIB;
		en = 1'b0;
		wb(1'b1, REG_CTRL, 32'h5);
		rchk(REG_CTRL, 32'h4, "calib ctrl");
		wb(1'b1, REG_CTRL, 32'h5);
		rchk(REG_CTRL, 32'h4, "locked enable");
		send(20, 2'h3);
		wb(1'b1, REG_COLIDX, 32'h5);
		wb(1'b1, REG_GAIN, 32'h1800);
		wb(1'b1, REG_OFFSET, 32'h0040);
		wb(1'b1, REG_OFFSET, 32'h0041);
		rchk(REG_STATUS, 32'h2, "offset error");
		rchk(REG_OFFSET, 32'h0040, "offset kept");
		rchk(REG_GAIN, 32'h1800, "gain");
		wb(1'b1, REG_STATUS, 32'h2);
		wb(1'b1, REG_CMD, 32'h2);
		idle();
		rchk(REG_STATUS, 32'h4, "saved");
		wb(1'b1, REG_GAIN, 32'h0800);
		wb(1'b1, REG_CMD, 32'h1);
		idle();
		rchk(REG_GAIN, 32'h1800, "reloaded");
		tab[5] = 32'h1800_0040;
		$display("calibration test done");
		md = MODE_USER;
		wb(1'b1, REG_CTRL, 32'h2);
		send(10, 2'h0);
		en = 1'b1;
		wb(1'b1, REG_CTRL, 32'h3);
		send(10, 2'h1);
		$display("user test done");
		tally_and_finish();
	end

	// Watchdog
	initial
	begin
		repeat (50000) @(posedge mclk);
		fails++;
		tally_and_finish();
	end
endmodule // cffc_column_corrector_bench
`default_nettype wire
